// ---- core/rcs_top.sv ----
// reset sequencing, start-up gating and reset-cause flags, APB slave
// assumes analog power-on and brown-out detectors drive SYS_RST and BOR_IN
//
// Overview of operation
// - watchdog timeout resets, clears watchdog and timeout flags
// - reset instruction resets, clears its flag
// - stack over/underflow resets and sets flag when enabled
// - power-up timer holds reset up to 64 ms
// - timer starts after power-on and brown-out release
// - execution waits for timer and released pin
// - expired timer: start ten cycles after pin
// - bad fetch address resets, clears violation flag
// - power-on loads documented flag defaults
// - wake-ups advance PC with given status flags
// - interrupt wake with irq enable vectors
// - pin reset clears flag; sleep sets status
// - only the causing flag changes; brownout also reloads cause bits 7 to 2 to power-on values
// - software may write flags; hardware clears and sets them too
// - software setting active flag causes no reset
// - software brownout enable works only in mode 01
// - brownout ready shows armed detector
// - cause register bit layout, bit five zero
// - unimplemented bits read zero, ignore writes
// - four brownout detector modes
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`include "rcs_params.svh"

module rcs_top #(
	parameter int unsigned POWER_UP_TIMER_CYCLES = `RCS_POWER_UP_TIMER_CYC,
	parameter int unsigned PC_W = 15
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic BOR_IN,
	input wire logic POWER_UP_TIMER_SELECT,
	input wire logic PIN_RESET_ENABLE,
	input wire logic PIN_RESET_N,
	input wire rcs_pkg::rcs_bormode_t BOR_MODE,
	input wire logic STACK_RESET_ENABLE,
	input wire logic BOR_DET_READY,
	input wire rcs_pkg::rcs_req_t REQ,
	input wire logic SLEEP_ENTER,
	input wire rcs_pkg::rcs_wake_t WAKE,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic [PC_W-1:0] PC_IN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [13:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic PREADY,
	output logic PSLVERR,
	output logic [31:0] PRDATA,
	output logic CORE_RESET,
	output logic RUN,
	output logic BOR_DET_ENABLE,
	output logic PC_LOAD,
	output logic [PC_W-1:0] PC_VALUE,
	output logic PUSH_RETURN,
	output logic TIMEOUT_FLAG,
	output logic POWERDOWN_FLAG
);
	import rcs_pkg::*;

	initial begin
		if (POWER_UP_TIMER_CYCLES < 1 || PC_W < 3)
			$error("rcs_top: unsupported parameters");
	end

	function automatic logic [13:0] byte_addr(input logic [11:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction

	rcs_state_t state_r;
	logic [31:0] power_up_timer_cnt_r;
	logic [3:0] dly_cnt_r;
	logic [7:0] cause_r;
	logic mem_violation_flag_r;
	logic sw_brownout_enable_r;
	logic vec_pend_r;
	logic bor_en;
	logic reset_req;
	logic wr, rd;
	logic hit_cause, hit_hi, hit_bor, hit_ctl, hit_stat;

	//--------------------------------------------------------------
	// reset requests
	//--------------------------------------------------------------
	// stack requests gated
	logic stk_o, stk_u;
	assign stk_o = REQ.stk_overflow & STACK_RESET_ENABLE;
	assign stk_u = REQ.stk_underflow & STACK_RESET_ENABLE;
	logic pin_rst;
	assign pin_rst = PIN_RESET_ENABLE & ~PIN_RESET_N;
	// a software write of an active value never lands here
	assign reset_req = state_r == RCS_ST_RUN &&
		(REQ.wdt_timeout | REQ.reset_instr | stk_o | stk_u |
		REQ.mem_violation);

	//--------------------------------------------------------------
	// brownout detector mode
	//--------------------------------------------------------------
	// four detector modes
	always_comb begin
		unique case (BOR_MODE)
			RCS_BOR_ON: bor_en = 1'b1;
			RCS_BOR_NOSLEEP: bor_en = state_r != RCS_ST_SLEEP;
			RCS_BOR_SW: bor_en = sw_brownout_enable_r;
			RCS_BOR_OFF: bor_en = 1'b0;
		endcase
	end
	assign BOR_DET_ENABLE = bor_en;

	//--------------------------------------------------------------
	// start-up sequencer
	//--------------------------------------------------------------
	// power_up_timer runs regardless of pin; pin checked when it expires
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_r <= RCS_ST_POWER;
			power_up_timer_cnt_r <= 32'h0;
			dly_cnt_r <= 4'h0;
		end else if (BOR_IN) begin
			state_r <= RCS_ST_POWER;
			power_up_timer_cnt_r <= 32'h0;
			dly_cnt_r <= 4'h0;
		end else begin
			unique case (state_r)
				RCS_ST_POWER: begin
					power_up_timer_cnt_r <= 32'h0;
					state_r <= POWER_UP_TIMER_SELECT ? RCS_ST_POWER_UP_TIMER : RCS_ST_PIN;
				end
				RCS_ST_POWER_UP_TIMER: begin
					power_up_timer_cnt_r <= power_up_timer_cnt_r + 32'h1;
					if (power_up_timer_cnt_r == POWER_UP_TIMER_CYCLES - 1)
						state_r <= RCS_ST_PIN;
				end
				RCS_ST_PIN: begin
					dly_cnt_r <= 4'h0;
					if (!pin_rst)
						state_r <= RCS_ST_DELAY;
				end
				RCS_ST_DELAY: begin
					dly_cnt_r <= dly_cnt_r + 4'h1;
					if (pin_rst)
						state_r <= RCS_ST_PIN;
					else if (dly_cnt_r == 4'(`RCS_PIN_DELAY_CYC - 1))
						state_r <= RCS_ST_RUN;
				end
				RCS_ST_RUN: begin
					if (pin_rst || reset_req)
						state_r <= RCS_ST_PIN;
					else if (SLEEP_ENTER)
						state_r <= RCS_ST_SLEEP;
				end
				RCS_ST_SLEEP: begin
					if (pin_rst)
						state_r <= RCS_ST_PIN;
					else if (WAKE.wdt_wake || WAKE.irq_wake)
						state_r <= RCS_ST_RUN;
				end
				default: state_r <= RCS_ST_POWER;
			endcase
		end
	end

	assign CORE_RESET = state_r != RCS_ST_RUN && state_r != RCS_ST_SLEEP;
	assign RUN = state_r == RCS_ST_RUN;

	//--------------------------------------------------------------
	// program counter load and wake-up vector
	//--------------------------------------------------------------
	logic wake_ev;
	assign wake_ev = state_r == RCS_ST_SLEEP && !pin_rst &&
		(WAKE.wdt_wake || WAKE.irq_wake);
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PC_LOAD <= 1'b0;
			PC_VALUE <= '0;
			PUSH_RETURN <= 1'b0;
			vec_pend_r <= 1'b0;
		end else begin
			PC_LOAD <= 1'b0;
			PUSH_RETURN <= 1'b0;
			if (state_r == RCS_ST_DELAY && !pin_rst &&
				dly_cnt_r == 4'(`RCS_PIN_DELAY_CYC - 1)) begin
				PC_LOAD <= 1'b1;
				PC_VALUE <= '0;
				vec_pend_r <= 1'b0;
			end else if (wake_ev) begin
				PC_LOAD <= 1'b1;
				PC_VALUE <= PC_IN + PC_W'(1);
				vec_pend_r <= WAKE.irq_wake & ~WAKE.wdt_wake & GLOBAL_IRQ_ENABLE;
			end else if (vec_pend_r && state_r == RCS_ST_RUN) begin
				PC_LOAD <= 1'b1;
				PUSH_RETURN <= 1'b1;
				PC_VALUE <= PC_W'(`RCS_IRQ_VECTOR);
				vec_pend_r <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------
	// apb decode
	//--------------------------------------------------------------
	assign wr = PSEL & PENABLE & PWRITE & PSTRB[0];
	assign rd = PSEL & ~PWRITE;
	assign hit_bor = PADDR == byte_addr(`RCS_IDX_BROWNOUT_CONTROL);
	assign hit_cause = PADDR == byte_addr(`RCS_IDX_RESET_CAUSE);
	assign hit_hi = PADDR == byte_addr(`RCS_IDX_RESET_CAUSE_HI);
	assign hit_ctl = PADDR == byte_addr(`RCS_IDX_STARTUP_CTRL);
	assign hit_stat = PADDR == byte_addr(`RCS_IDX_STARTUP_STAT);
	assign PREADY = 1'b1;
	// unmapped addresses answer with an error and read zero
	assign PSLVERR = PSEL & PENABLE &
		~(hit_bor | hit_cause | hit_hi | hit_ctl | hit_stat);

	//--------------------------------------------------------------
	// cause flags
	//--------------------------------------------------------------
	// hardware set wins over a same-cycle software write
	logic [7:0] sw_cause;
	always_comb begin
		sw_cause = cause_r;
		if (wr && hit_cause)
			sw_cause = PWDATA[7:0] & `RCS_CAUSE_MASK;
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cause_r <= `RCS_CAUSE_POR;
		end else if (BOR_IN) begin
			cause_r <= `RCS_CAUSE_POR & ~(8'h1 << `RCS_B_POR) |
				(cause_r & (8'h1 << `RCS_B_POR));
			cause_r[`RCS_B_BOR] <= 1'b0;
		end else begin
			cause_r <= sw_cause;
			if (state_r == RCS_ST_RUN) begin
				if (REQ.wdt_timeout)
					cause_r[`RCS_B_WDT] <= 1'b0;
				if (REQ.reset_instr)
					cause_r[`RCS_B_RI] <= 1'b0;
				if (stk_o)
					cause_r[`RCS_B_STACK_OVERFLOW_FLAG] <= 1'b1;
				if (stk_u)
					cause_r[`RCS_B_STACK_UNDERFLOW_FLAG] <= 1'b1;
			end
			if (pin_rst && (state_r == RCS_ST_RUN ||
				state_r == RCS_ST_SLEEP))
				cause_r[`RCS_B_PIN] <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mem_violation_flag_r <= 1'b1;
		end else if (BOR_IN) begin
			mem_violation_flag_r <= mem_violation_flag_r;
		end else if (state_r == RCS_ST_RUN && REQ.mem_violation) begin
			mem_violation_flag_r <= 1'b0;
		end else if (wr && hit_hi) begin
			mem_violation_flag_r <= PWDATA[`RCS_B_MEM_VIOLATION_FLAG];
		end
	end

	//--------------------------------------------------------------
	// status flags: timeout and powerdown
	//--------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			TIMEOUT_FLAG <= 1'b1;
			POWERDOWN_FLAG <= 1'b1;
		end else if (BOR_IN) begin
			TIMEOUT_FLAG <= 1'b1;
			POWERDOWN_FLAG <= 1'b1;
		end else if (state_r == RCS_ST_RUN && REQ.wdt_timeout) begin
			TIMEOUT_FLAG <= 1'b0;
		end else if (state_r == RCS_ST_RUN && SLEEP_ENTER && !pin_rst &&
			!reset_req) begin
			POWERDOWN_FLAG <= 1'b0;
		end else if (state_r == RCS_ST_SLEEP) begin
			if (pin_rst) begin
				TIMEOUT_FLAG <= 1'b1;
				POWERDOWN_FLAG <= 1'b0;
			end else if (WAKE.wdt_wake) begin
				TIMEOUT_FLAG <= 1'b0;
				POWERDOWN_FLAG <= 1'b0;
			end else if (WAKE.irq_wake) begin
				TIMEOUT_FLAG <= 1'b1;
				POWERDOWN_FLAG <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------
	// brownout control
	//--------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sw_brownout_enable_r <= 1'b1;
		end else if (BOR_IN) begin
			sw_brownout_enable_r <= 1'b1;
		end else if (wr && hit_bor) begin
			sw_brownout_enable_r <= PWDATA[`RCS_B_SW_BROWNOUT_ENABLE];
		end
	end

	//--------------------------------------------------------------
	// read data
	//--------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PRDATA <= 32'h0;
		end else if (rd && !PENABLE) begin
			PRDATA <= 32'h0;
			if (hit_bor) begin
				PRDATA[`RCS_B_SW_BROWNOUT_ENABLE] <= sw_brownout_enable_r;
				PRDATA[`RCS_B_BROWNOUT_READY] <= bor_en & BOR_DET_READY;
			end
			if (hit_cause)
				PRDATA[7:0] <= cause_r & `RCS_CAUSE_MASK;
			if (hit_hi)
				PRDATA[7:0] <= {6'h0, mem_violation_flag_r, 1'b0};
			if (hit_stat)
				PRDATA[7:0] <= {3'h0, TIMEOUT_FLAG, POWERDOWN_FLAG,
					state_r};
		end
	end
endmodule

// ---- core/rcs_params.svh ----
// reset-cause and start-up constants: offsets, fields, reset values, timing
// assumes inclusion by the top module and by the testbench
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// register printed offsets are indices; byte address is four times
`define RCS_IDX_BROWNOUT_CONTROL 12'h811
`define RCS_IDX_RESET_CAUSE 12'h813
`define RCS_IDX_RESET_CAUSE_HI 12'h814
`define RCS_IDX_STARTUP_CTRL 12'h820
`define RCS_IDX_STARTUP_STAT 12'h821

// reset_cause_flags fields
`define RCS_B_STACK_OVERFLOW_FLAG 7
`define RCS_B_STACK_UNDERFLOW_FLAG 6
`define RCS_B_WDT 4
`define RCS_B_PIN 3
`define RCS_B_RI 2
`define RCS_B_POR 1
`define RCS_B_BOR 0
`define RCS_CAUSE_MASK 8'hdf
`define RCS_CAUSE_POR 8'h1c
// hi register: memory violation flag
`define RCS_B_MEM_VIOLATION_FLAG 1
`define RCS_HI_MASK 8'h02
// brownout_control fields
`define RCS_B_SW_BROWNOUT_ENABLE 7
`define RCS_B_BROWNOUT_READY 0

// status flags on power-on: timeout 1, powerdown 1
`define RCS_POWER_UP_TIMER_MS 64
`define RCS_CLK_MHZ 250
`define RCS_POWER_UP_TIMER_CYC (`RCS_POWER_UP_TIMER_MS * 1000 * `RCS_CLK_MHZ)
`define RCS_PIN_DELAY_CYC 10
`define RCS_IRQ_VECTOR 15'h0004

`endif

// ---- core/rcs_pkg.sv ----
// types for the reset-cause and start-up block
// assumes rcs_params.svh defines the constants
package rcs_pkg;
	typedef enum logic [1:0] {
		RCS_BOR_OFF = 2'b00,
		RCS_BOR_SW = 2'b01,
		RCS_BOR_NOSLEEP = 2'b10,
		RCS_BOR_ON = 2'b11
	} rcs_bormode_t;

	typedef enum logic [2:0] {
		RCS_ST_POWER = 3'b000,
		RCS_ST_POWER_UP_TIMER = 3'b001,
		RCS_ST_PIN = 3'b010,
		RCS_ST_DELAY = 3'b011,
		RCS_ST_RUN = 3'b100,
		RCS_ST_SLEEP = 3'b101
	} rcs_state_t;

	// reset requests from the core and its watchdog
	typedef struct packed {
		logic wdt_timeout;
		logic reset_instr;
		logic stk_overflow;
		logic stk_underflow;
		logic mem_violation;
	} rcs_req_t;

	// sleep wake-up events
	typedef struct packed {
		logic wdt_wake;
		logic irq_wake;
	} rcs_wake_t;
endpackage

// ---- sim/rcs_top_asserts.sv ----
// checker: start-up gating and reset entry seen at the top ports
// assumes a bind into rcs_top with the timer length handed down
`timescale 1ns/1ns
module rcs_top_asserts import rcs_pkg::*; #(
	parameter int unsigned POWER_UP_TIMER_CYCLES = 20,
	parameter int unsigned PC_W = 15
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic BOR_IN,
	input wire logic POWER_UP_TIMER_SELECT,
	input wire logic PIN_RESET_ENABLE,
	input wire logic PIN_RESET_N,
	input wire logic STACK_RESET_ENABLE,
	input wire rcs_pkg::rcs_req_t REQ,
	input wire rcs_pkg::rcs_wake_t WAKE,
	input wire logic GLOBAL_IRQ_ENABLE,
	input wire logic [PC_W-1:0] PC_IN,
	input wire logic CORE_RESET,
	input wire logic RUN,
	input wire logic PC_LOAD,
	input wire logic [PC_W-1:0] PC_VALUE,
	input wire logic PUSH_RETURN,
	input wire logic TIMEOUT_FLAG,
	input wire logic POWERDOWN_FLAG
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);
	logic [31:0] age_r;
	logic sleeping;
	assign sleeping = !RUN && !CORE_RESET;
	// ------------------------------------------
	// age since power-on or brown-out release
	// ------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			age_r <= 32'h0;
		else if (BOR_IN)
			age_r <= 32'h0;
		else if (age_r != 32'hffffffff)
			age_r <= age_r + 32'h1;
	end
	property p_power_up_timer_hold;
		RUN && POWER_UP_TIMER_SELECT |-> age_r > POWER_UP_TIMER_CYCLES;
	endproperty
	a_power_up_timer_hold: assert property (p_power_up_timer_hold)
		else $error("execution before timer end");
	property p_pin_hold;
		PIN_RESET_ENABLE && !PIN_RESET_N |=> !RUN;
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("running with pin low");
	property p_pin_delay;
		$rose(RUN) && $past(CORE_RESET) && PIN_RESET_ENABLE
			|-> $past(PIN_RESET_N, 10);
	endproperty
	a_pin_delay: assert property (p_pin_delay)
		else $error("start too soon after pin");
	property p_zero_pc;
		$rose(RUN) && $past(CORE_RESET) |-> PC_LOAD && PC_VALUE == '0;
	endproperty
	a_zero_pc: assert property (p_zero_pc)
		else $error("pc not zero at start");
	property p_instr;
		RUN && REQ.reset_instr |=> CORE_RESET;
	endproperty
	a_instr: assert property (p_instr)
		else $error("no reset on instruction");
	property p_stack;
		RUN && STACK_RESET_ENABLE && (REQ.stk_overflow || REQ.stk_underflow)
			|=> CORE_RESET;
	endproperty
	a_stack: assert property (p_stack)
		else $error("no reset on stack fault");
	property p_wdt_wake;
		sleeping && WAKE.wdt_wake |=> RUN && PC_LOAD
			&& PC_VALUE == $past(PC_IN) + 1'b1
			&& !TIMEOUT_FLAG && !POWERDOWN_FLAG;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake)
		else $error("bad watchdog wake");
	property p_irq_wake;
		sleeping && WAKE.irq_wake |=> RUN && TIMEOUT_FLAG && !POWERDOWN_FLAG;
	endproperty
	a_irq_wake: assert property (p_irq_wake)
		else $error("bad interrupt wake");
	property p_irq_vec;
		sleeping && WAKE.irq_wake && GLOBAL_IRQ_ENABLE |-> ##[2:3]
			(PC_LOAD && PUSH_RETURN && PC_VALUE == PC_W'(3'h4));
	endproperty
	a_irq_vec: assert property (p_irq_vec)
		else $error("no vector after wake");
endmodule

bind rcs_top rcs_top_asserts #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES), .PC_W(PC_W)) u_chk (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .BOR_IN(BOR_IN),
	.POWER_UP_TIMER_SELECT(POWER_UP_TIMER_SELECT), .PIN_RESET_ENABLE(PIN_RESET_ENABLE),
	.PIN_RESET_N(PIN_RESET_N), .STACK_RESET_ENABLE(STACK_RESET_ENABLE),
	.REQ(REQ), .WAKE(WAKE), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .PC_IN(PC_IN),
	.CORE_RESET(CORE_RESET), .RUN(RUN), .PC_LOAD(PC_LOAD),
	.PC_VALUE(PC_VALUE), .PUSH_RETURN(PUSH_RETURN),
	.TIMEOUT_FLAG(TIMEOUT_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG)
);

// ---- sim/rcs_top_tb.sv ----
// testbench for the reset-cause and start-up block
// assumes the timer shortened to 20 cycles, APB with no wait states
`timescale 1ns/1ns
`include "rcs_params.svh"
`define CHK(n, x, g) begin checks_done++; if ((g) !== (x)) begin \
	n_errors++; $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module rcs_top_tb;
	import rcs_pkg::*;
	logic SYS_CLK = 0, SYS_RST = 1, BOR_IN = 0, POWER_UP_TIMER_SELECT = 1, GLOBAL_IRQ_ENABLE = 0;
	logic PIN_RESET_ENABLE = 1, PIN_RESET_N = 0, STACK_RESET_ENABLE = 1;
	logic BOR_DET_READY = 1, SLEEP_ENTER = 0, PSEL = 0, PENABLE = 0;
	logic PWRITE = 0, PREADY, PSLVERR, CORE_RESET, RUN, BOR_DET_ENABLE;
	logic PC_LOAD, PUSH_RETURN, TIMEOUT_FLAG, POWERDOWN_FLAG;
	logic [13:0] PADDR = 14'h0;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic [3:0] PSTRB = 4'hf;
	logic [14:0] PC_IN = 15'h0, PC_VALUE;
	rcs_bormode_t BOR_MODE = RCS_BOR_ON;
	rcs_req_t REQ = '0;
	rcs_wake_t WAKE = '0;
	int n_errors = 0, checks_done = 0;
	localparam logic [13:0] BCTL = {`RCS_IDX_BROWNOUT_CONTROL, 2'b00};
	localparam logic [13:0] CAUSE = {`RCS_IDX_RESET_CAUSE, 2'b00};
	localparam logic [13:0] HI = {`RCS_IDX_RESET_CAUSE_HI, 2'b00};
	always #2 SYS_CLK = ~SYS_CLK;
	rcs_top #(.POWER_UP_TIMER_CYCLES(20)) i_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
		.BOR_IN(BOR_IN), .POWER_UP_TIMER_SELECT(POWER_UP_TIMER_SELECT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
		.PIN_RESET_ENABLE(PIN_RESET_ENABLE), .PIN_RESET_N(PIN_RESET_N),
		.BOR_MODE(BOR_MODE), .STACK_RESET_ENABLE(STACK_RESET_ENABLE),
		.BOR_DET_READY(BOR_DET_READY), .REQ(REQ), .SLEEP_ENTER(SLEEP_ENTER),
		.WAKE(WAKE), .PC_IN(PC_IN), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
		.CORE_RESET(CORE_RESET), .RUN(RUN), .BOR_DET_ENABLE(BOR_DET_ENABLE),
		.PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .PUSH_RETURN(PUSH_RETURN),
		.TIMEOUT_FLAG(TIMEOUT_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG));
	// --------------------
	// bus and sequencing
	// --------------------
	task automatic apb(input logic w, input logic [13:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic e);
		int k;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {24'h0, d};
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge SYS_CLK);
			k++;
		end while (PREADY !== 1'b1 && k < 50);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [13:0] a, input logic [31:0] x, string n);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 8'h0, q, e);
		`CHK(n, x, q)
	endtask
	task automatic wait_run();
		int k;
		k = 0;
		do begin
			@(posedge SYS_CLK);
			k++;
		end while (RUN !== 1'b1 && k < 200);
		`CHK("run", 1'b1, RUN)
	endtask
	// pulse first, then let the sequencer leave run before waiting
	task automatic req(input rcs_req_t r);
		REQ <= r;
		@(posedge SYS_CLK);
		REQ <= '0;
		repeat (2) @(posedge SYS_CLK);
		wait_run();
	endtask
	task automatic pin_pulse();
		PIN_RESET_N <= 1'b0;
		repeat (5) @(posedge SYS_CLK);
		PIN_RESET_N <= 1'b1;
		wait_run();
	endtask
	task automatic sleep_wake(input rcs_wake_t w);
		SLEEP_ENTER <= 1'b1;
		@(posedge SYS_CLK);
		SLEEP_ENTER <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		`CHK("asleep", 1'b0, RUN)
		WAKE <= w;
		@(posedge SYS_CLK);
		WAKE <= '0;
		if (w != '0)
			wait_run();
	endtask
	// --------------------
	// scenarios
	// --------------------
	task automatic t_por();
		int k;
		rd(CAUSE, 32'h1c, "cause");
		rd(HI, 32'h2, "mem_violation_flag");
		rd(BCTL, 32'h81, "brownout_control");
		`CHK("to_pd", 2'b11, {TIMEOUT_FLAG, POWERDOWN_FLAG})
		repeat (40) @(posedge SYS_CLK);
		`CHK("held", 1'b0, RUN)
		PIN_RESET_N <= 1'b1;
		k = 0;
		while (RUN !== 1'b1 && k < 50) begin
			@(posedge SYS_CLK);
			k++;
		end
		`CHK("pin_delay", 1'b1, k inside {[10:12]})
		$display("test por finished");
	endtask
	task automatic t_causes();
		wr(CAUSE, 8'h1f);
		req(5'h08);
		rd(CAUSE, 32'h1b, "instr");
		req(5'h10);
		rd(CAUSE, 32'h0b, "wdt");
		`CHK("wdt_to", 1'b0, TIMEOUT_FLAG)
		req(5'h04);
		rd(CAUSE, 32'h8b, "ovf");
		STACK_RESET_ENABLE <= 1'b0;
		REQ <= 5'h02;
		@(posedge SYS_CLK);
		REQ <= '0;
		repeat (3) @(posedge SYS_CLK);
		`CHK("no_stk", 1'b1, RUN)
		STACK_RESET_ENABLE <= 1'b1;
		req(5'h02);
		rd(CAUSE, 32'hcb, "unf");
		pin_pulse();
		rd(CAUSE, 32'hc3, "pin");
		`CHK("pin_st", 2'b01, {TIMEOUT_FLAG, POWERDOWN_FLAG})
		$display("test causes finished");
	endtask
	task automatic t_sw();
		logic [31:0] q;
		logic e;
		wr(CAUSE, 8'hff);
		rd(CAUSE, 32'hdf, "bit5");
		wr(CAUSE, 8'h00);
		`CHK("no_rst", 1'b1, RUN)
		rd(CAUSE, 32'h00, "active");
		wr(CAUSE, 8'h1f);
		rd(CAUSE, 32'h1f, "clear");
		req(5'h01);
		rd(HI, 32'h0, "mem_violation_flag");
		wr(HI, 8'hff);
		rd(HI, 32'h2, "mem_violation_flag_set");
		apb(1'b0, 14'h2048, 8'h0, q, e);
		`CHK("unmap_err", 1'b1, e)
		`CHK("unmap_q", 32'h0, q)
		$display("test software finished");
	endtask
	task automatic t_bor();
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 2; s++) begin
				logic x;
				x = m >= 2 || (m == 1 && s == 1);
				BOR_MODE <= rcs_bormode_t'(m);
				wr(BCTL, {s[0], 7'h0});
				`CHK("bor_en", x, BOR_DET_ENABLE)
				rd(BCTL, {24'h0, s[0], 6'h0, x}, "brownout_control");
			end
		end
		BOR_MODE <= RCS_BOR_ON;
		wr(CAUSE, 8'hdf);
		BOR_IN <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		BOR_IN <= 1'b0;
		wait_run();
		rd(CAUSE, 32'h1e, "brownout");
		rd(HI, 32'h2, "mem_violation_flag_kept");
		$display("test brownout finished");
	endtask
	task automatic t_sleep();
		PC_IN <= 15'h123;
		sleep_wake(2'b10);
		`CHK("wdt_wake", 2'b00, {TIMEOUT_FLAG, POWERDOWN_FLAG})
		GLOBAL_IRQ_ENABLE <= 1'b1;
		sleep_wake(2'b01);
		`CHK("irq_wake", 2'b10, {TIMEOUT_FLAG, POWERDOWN_FLAG})
		sleep_wake(2'b00);
		pin_pulse();
		`CHK("pin_sleep", 2'b10, {TIMEOUT_FLAG, POWERDOWN_FLAG})
		rd(CAUSE, 32'h16, "pin_sleep");
		$display("test sleep finished");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		t_por();
		t_causes();
		t_sw();
		t_bor();
		t_sleep();
		conclude();
	end
endmodule
